// ===== logic/rlf_pkg.sv
// package of constants for the rms limit flag and unit scaling block
package rlf_pkg;
   // ********************
   // register offsets
   // ********************
   localparam logic [11:0] OFF_CURRENT_RMS_A = 12'h1CC;
   localparam logic [11:0] OFF_VOLTAGE_RMS_A = 12'h1D0;
   localparam logic [11:0] OFF_POWER_A = 12'h1D4;
   localparam logic [11:0] OFF_ENERGY_A = 12'h1D8;
   localparam logic [11:0] OFF_SCALED_CURRENT_A = 12'h831;
   localparam logic [11:0] OFF_SCALED_VOLTAGE_A = 12'h832;
   localparam logic [11:0] OFF_SCALED_POWER_A = 12'h833;
   localparam logic [11:0] OFF_SCALED_ENERGY_A = 12'h834;
   localparam logic [11:0] OFF_OV_THRESHOLD = 12'h100;
   localparam logic [11:0] OFF_OC_THRESHOLD = 12'h102;
   localparam logic [11:0] OFF_UV_THRESHOLD = 12'h104;
   localparam logic [11:0] OFF_IRQ_FLAG = 12'h106;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h108;
   localparam logic [11:0] OFF_ADC_RATE = 12'h10A;
   localparam logic [11:0] OFF_CUR_COEFF = 12'h10C;
   localparam logic [11:0] OFF_VOLT_COEFF = 12'h10E;
   localparam logic [11:0] OFF_PWR_COEFF = 12'h110;
   localparam logic [11:0] OFF_ENR_COEFF = 12'h112;
   localparam logic [11:0] OFF_PHASE_FLAGS_A = 12'h114;
   localparam logic [11:0] OFF_PHASE_FLAGS_B = 12'h116;
   localparam logic [11:0] OFF_PHASE_FLAGS_C = 12'h118;
   // ********************
   // fields and reset values
   // ********************
   localparam int RMS_CMP_HI = 23;
   localparam int RMS_CMP_LO = 8;
   localparam int FRAC_BITS = 16;
   localparam int FLAG_OC = 0;
   localparam int FLAG_OV = 1;
   localparam int FLAG_UV = 2;
   localparam logic [15:0] ADC_RATE_RESET = 16'h013F;
   localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
   localparam logic [15:0] COEFF_RESET = 16'h0000;
   localparam int FRAME_CLK_MULT = 8;
endpackage : rlf_pkg

// ===== logic/rlf_limit_scale.sv
// rms limit flags, frame timer and virtual register scaling
`timescale 1ns/1ns
// How it works
// - thresholds compare against rms result bits 23 to 8
// - rms voltage above threshold sets overvoltage; current above sets overcurrent
// - interrupt request when a set flag has its enable bit
// - flags stay set until reset or host write clears them
// - frame period is (divider plus one) times eight clocks, divider resets 319
// - virtual read returns meter result times its matching coefficient
// - scaled result has sixteen fractional bits
// - rms voltage not above undervoltage threshold sets undervoltage
// - only mask-enabled flag bits generate the interrupt
// - each phase keeps its own copy of oc, ov and uv flags
module rlf_limit_scale
   import rlf_pkg::*;
#(
   parameter int PHASES = 3
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [PHASES*24-1:0] voltage_rms_result,
   input wire logic [PHASES*24-1:0] current_rms_result,
   input wire logic [31:0] power_result_a,
   input wire logic [31:0] energy_result_a,
   input wire logic result_valid,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   output logic frame_tick,
   output logic irq
);
   // ********************
   // programmable registers
   // ********************
   logic [15:0] overvoltage_threshold;
   logic [15:0] overcurrent_threshold;
   logic [15:0] undervoltage_threshold;
   logic [15:0] adc_rate_divider;
   logic [15:0] current_scale_coeff;
   logic [15:0] voltage_scale_coeff;
   logic [15:0] power_scale_coeff;
   logic [15:0] energy_scale_coeff;
   logic [2:0] irq_mask;
   logic [2:0] irq_flag;
   logic [2:0] phase_flags [PHASES];
   logic [18:0] frame_cnt;
   logic [2:0] phase_hit [PHASES];
   logic [2:0] next_irq_flag;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         overvoltage_threshold <= THRESHOLD_RESET;
         overcurrent_threshold <= THRESHOLD_RESET;
         undervoltage_threshold <= THRESHOLD_RESET;
         adc_rate_divider <= ADC_RATE_RESET;
         current_scale_coeff <= COEFF_RESET;
         voltage_scale_coeff <= COEFF_RESET;
         power_scale_coeff <= COEFF_RESET;
         energy_scale_coeff <= COEFF_RESET;
         irq_mask <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == OFF_OV_THRESHOLD) begin
            overvoltage_threshold <= reg_wdata[15:0];
         end else if (reg_addr == OFF_OC_THRESHOLD) begin
            overcurrent_threshold <= reg_wdata[15:0];
         end else if (reg_addr == OFF_UV_THRESHOLD) begin
            undervoltage_threshold <= reg_wdata[15:0];
         end else if (reg_addr == OFF_IRQ_MASK) begin
            irq_mask <= reg_wdata[2:0];
         end else if (reg_addr == OFF_ADC_RATE) begin
            adc_rate_divider <= reg_wdata[15:0];
         end else if (reg_addr == OFF_CUR_COEFF) begin
            current_scale_coeff <= reg_wdata[15:0];
         end else if (reg_addr == OFF_VOLT_COEFF) begin
            voltage_scale_coeff <= reg_wdata[15:0];
         end else if (reg_addr == OFF_PWR_COEFF) begin
            power_scale_coeff <= reg_wdata[15:0];
         end else if (reg_addr == OFF_ENR_COEFF) begin
            energy_scale_coeff <= reg_wdata[15:0];
         end
      end
   end

   // ********************
   // frame timer
   // ********************
   logic [18:0] frame_last;
   assign frame_last = 19'((32'(adc_rate_divider) + 1) * FRAME_CLK_MULT - 1);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt <= 19'h00000;
         frame_tick <= 1'b0;
      end else if (frame_cnt >= frame_last) begin
         frame_cnt <= 19'h00000;
         frame_tick <= 1'b1;
      end else begin
         frame_cnt <= frame_cnt + 19'h00001;
         frame_tick <= 1'b0;
      end
   end

   // ********************
   // limit comparison
   // ********************
   always_comb begin
      next_irq_flag = 3'h0;
      for (int p = 0; p < PHASES; p++) begin
         phase_hit[p][FLAG_OV] = result_valid &&
            (voltage_rms_result[p*24+RMS_CMP_LO +: 16] > overvoltage_threshold);
         phase_hit[p][FLAG_OC] = result_valid &&
            (current_rms_result[p*24+RMS_CMP_LO +: 16] > overcurrent_threshold);
         phase_hit[p][FLAG_UV] = result_valid &&
            !(voltage_rms_result[p*24+RMS_CMP_LO +: 16] > undervoltage_threshold);
         next_irq_flag = next_irq_flag | phase_hit[p];
      end
   end

   // set wins over a clear arriving in the same cycle
   logic flag_clear;
   assign flag_clear = reg_wr && (reg_addr == OFF_IRQ_FLAG);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flag <= 3'h0;
      end else begin
         irq_flag <= (irq_flag & ~(flag_clear ? reg_wdata[2:0] : 3'h0)) | next_irq_flag;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < PHASES; p++) phase_flags[p] <= 3'h0;
      end else begin
         for (int p = 0; p < PHASES; p++) begin
            if (reg_wr && reg_addr == OFF_PHASE_FLAGS_A + 12'(2 * p)) begin
               phase_flags[p] <= (phase_flags[p] & ~reg_wdata[2:0]) | phase_hit[p];
            end else begin
               phase_flags[p] <= phase_flags[p] | phase_hit[p];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_flag & irq_mask);
      end
   end

   // ********************
   // read path with scaling
   // ********************
   // product keeps the low 32 bits: integer units above bit 16, fraction below
   function automatic logic [31:0] scale(input logic [31:0] res, input logic [15:0] cc);
      logic [47:0] prod;
      prod = 48'(res) * 48'(cc);
      return prod[31:0];
   endfunction : scale

   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_addr == OFF_CURRENT_RMS_A) begin
         next_rdata = {8'h00, current_rms_result[23:0]};
      end else if (reg_addr == OFF_VOLTAGE_RMS_A) begin
         next_rdata = {8'h00, voltage_rms_result[23:0]};
      end else if (reg_addr == OFF_POWER_A) begin
         next_rdata = power_result_a;
      end else if (reg_addr == OFF_ENERGY_A) begin
         next_rdata = energy_result_a;
      end else if (reg_addr == OFF_SCALED_CURRENT_A) begin
         next_rdata = scale({8'h00, current_rms_result[23:0]}, current_scale_coeff);
      end else if (reg_addr == OFF_SCALED_VOLTAGE_A) begin
         next_rdata = scale({8'h00, voltage_rms_result[23:0]}, voltage_scale_coeff);
      end else if (reg_addr == OFF_SCALED_POWER_A) begin
         next_rdata = scale(power_result_a, power_scale_coeff);
      end else if (reg_addr == OFF_SCALED_ENERGY_A) begin
         next_rdata = scale(energy_result_a, energy_scale_coeff);
      end else if (reg_addr == OFF_OV_THRESHOLD) begin
         next_rdata = {16'h0000, overvoltage_threshold};
      end else if (reg_addr == OFF_OC_THRESHOLD) begin
         next_rdata = {16'h0000, overcurrent_threshold};
      end else if (reg_addr == OFF_UV_THRESHOLD) begin
         next_rdata = {16'h0000, undervoltage_threshold};
      end else if (reg_addr == OFF_IRQ_FLAG) begin
         next_rdata = {29'h0, irq_flag};
      end else if (reg_addr == OFF_IRQ_MASK) begin
         next_rdata = {29'h0, irq_mask};
      end else if (reg_addr == OFF_ADC_RATE) begin
         next_rdata = {16'h0000, adc_rate_divider};
      end else if (reg_addr == OFF_CUR_COEFF) begin
         next_rdata = {16'h0000, current_scale_coeff};
      end else if (reg_addr == OFF_VOLT_COEFF) begin
         next_rdata = {16'h0000, voltage_scale_coeff};
      end else if (reg_addr == OFF_PWR_COEFF) begin
         next_rdata = {16'h0000, power_scale_coeff};
      end else if (reg_addr == OFF_ENR_COEFF) begin
         next_rdata = {16'h0000, energy_scale_coeff};
      end else if (reg_addr == OFF_PHASE_FLAGS_A) begin
         next_rdata = {29'h0, phase_flags[0]};
      end else if (reg_addr == OFF_PHASE_FLAGS_B && PHASES > 1) begin
         next_rdata = {29'h0, phase_flags[1 % PHASES]};
      end else if (reg_addr == OFF_PHASE_FLAGS_C && PHASES > 2) begin
         next_rdata = {29'h0, phase_flags[2 % PHASES]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end

   // ********************
   // checks
   // ********************
   // gathers every phase's overvoltage copy so the check sees all phases
   logic [PHASES-1:0] phase_ov_seen;
   always_comb begin
      phase_ov_seen = '0;
      for (int p = 0; p < PHASES; p++) begin
         phase_ov_seen[p] = phase_flags[p][FLAG_OV];
      end
   end

   sequence s_ov_event;
      result_valid && (voltage_rms_result[23:8] > overvoltage_threshold);
   endsequence
   sequence s_flag_up;
      ##1 irq_flag[FLAG_OV];
   endsequence

   chk_ov_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ov_event |-> s_flag_up) else $error("overvoltage did not set flag");
   chk_oc_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      result_valid && (current_rms_result[23:8] > overcurrent_threshold)
      |=> irq_flag[FLAG_OC]) else $error("overcurrent did not set flag");
   chk_uv_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      result_valid && !(voltage_rms_result[23:8] > undervoltage_threshold)
      |=> irq_flag[FLAG_UV]) else $error("undervoltage did not set flag");
   chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq_flag[FLAG_OV] && !flag_clear |=> irq_flag[FLAG_OV]) else $error("flag dropped");
   chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      flag_clear && reg_wdata[FLAG_OC] && !next_irq_flag[FLAG_OC] |=> !irq_flag[FLAG_OC])
      else $error("flag not cleared");
   chk_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (irq_flag & irq_mask) == 3'h0 |=> !irq) else $error("irq without enabled flag");
   chk_irq_raised: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (irq_flag & irq_mask) != 3'h0 |=> irq) else $error("irq missing");
   chk_phase_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq_flag[FLAG_OV] && !$past(irq_flag[FLAG_OV]) |-> phase_ov_seen != '0)
      else $error("phase copy missing");
   chk_frame_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_tick && adc_rate_divider == 16'h0000 |-> ##8 frame_tick)
      else $error("frame period wrong");
   chk_scaled_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFF_SCALED_CURRENT_A |=>
      reg_rdata == {8'h00, $past(current_rms_result[23:0])} *
      {16'h0000, $past(current_scale_coeff)})
      else $error("scaled read wrong");
endmodule : rlf_limit_scale

// ===== bench/rlf_host.sv
// host model driving the register strobes of the limit block
`timescale 1ns/1ns
module rlf_host (
   input wire logic ref_clk,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic reg_wr,
   output logic reg_rd,
   output logic [11:0] reg_addr,
   output logic [31:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'hFFF;
      reg_wdata = 32'h0;
   end
   // idle bus shows inverted values so stale data never passes as fresh
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rvalid ? reg_rdata : 'x;
   endtask : rd
endmodule : rlf_host

// ===== bench/rlf_limit_scale_tb_top.sv
// self-checking bench for the rms limit flag and scaling block
`timescale 1ns/1ns
module rlf_limit_scale_tb_top;
   import rlf_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [71:0] voltage_rms_result = '0;
   logic [71:0] current_rms_result = '0;
   logic [31:0] power_result_a = '0;
   logic [31:0] energy_result_a = '0;
   logic result_valid = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, frame_tick, irq;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, got;
   int miscompares = 0;
   int n_tests = 0;
   int gflag = 0;
   int mask = 0;
   int n;
   int thr[3] = '{0, 0, 0};
   int pflag[3] = '{0, 0, 0};
   longint cf[4];
   longint raw[4];
   always #50 ref_clk = ~ref_clk;
   rlf_limit_scale dut (.ref_clk, .rst_n, .voltage_rms_result, .current_rms_result,
      .power_result_a, .energy_result_a, .result_valid, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_rvalid, .frame_tick, .irq);
   rlf_host host (.ref_clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata);
   // ********************
   // checking helpers
   // ********************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      host.rd(a, got);
      chk(got, e);
   endtask : rc
   // writes also update the reference copy of thresholds, mask and flags
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      host.wr(a, d);
      if (a == OFF_IRQ_FLAG) gflag &= ~d[2:0];
      if (a == OFF_IRQ_MASK) mask = d[2:0];
      for (int i = 0; i < 3; i++) begin
         if (a == OFF_OV_THRESHOLD + 2 * i) thr[i] = d[15:0];
         if (a == OFF_PHASE_FLAGS_A + 2 * i) pflag[i] &= ~d[2:0];
      end
   endtask : w
   task automatic pulse(input logic [71:0] v, input logic [71:0] c);
      @(posedge ref_clk);
      #1;
      voltage_rms_result = v;
      current_rms_result = c;
      result_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      result_valid = 1'b0;
      for (int p = 0; p < 3; p++) begin
         int f = 0;
         if (v[p * 24 + 8 +: 16] > thr[0]) f |= 2;
         if (c[p * 24 + 8 +: 16] > thr[1]) f |= 1;
         if (v[p * 24 + 8 +: 16] <= thr[2]) f |= 4;
         pflag[p] |= f;
         gflag |= f;
      end
      repeat (2) @(posedge ref_clk);
      #1;
      chk(irq, |(gflag & mask));
   endtask : pulse
   task automatic flags;
      rc(OFF_IRQ_FLAG, gflag);
      for (int p = 0; p < 3; p++) rc(12'(OFF_PHASE_FLAGS_A + 2 * p), pflag[p]);
   endtask : flags
   task automatic period(input int e);
      int c = 0;
      for (int k = 0; k < 2; k++) begin
         c = 0;
         do begin
            @(posedge ref_clk);
            #1;
            c++;
         end while (frame_tick !== 1'b1 && c < 3000);
      end
      chk(c, e);
   endtask : period
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   // ********************
   // test sequence
   // ********************
   initial begin
      n = $urandom(32'h391A);
      repeat (10) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      rc(OFF_ADC_RATE, 32'h0000013F);
      rc(OFF_OV_THRESHOLD, 32'h0);
      rc(OFF_CUR_COEFF, 32'h0);
      rc(12'h7FE, 32'h0);
      flags();
      $display("test reset done");
      period(2560);
      n = $urandom_range(40, 1);
      w(OFF_ADC_RATE, n);
      period((n + 1) * 8);
      w(OFF_ADC_RATE, 32'h0);
      period(8);
      $display("test frame done");
      for (int r = 0; r < 3; r++) begin
         voltage_rms_result[23:0] = 24'($urandom());
         current_rms_result[23:0] = 24'($urandom());
         power_result_a = $urandom();
         energy_result_a = $urandom();
         raw = '{current_rms_result[23:0], voltage_rms_result[23:0], power_result_a,
            energy_result_a};
         for (int k = 0; k < 4; k++) begin
            cf[k] = $urandom_range(16'hFFFF, 0);
            w(12'(OFF_CUR_COEFF + 2 * k), 32'(cf[k]));
         end
         for (int k = 0; k < 4; k++) begin
            rc(12'(OFF_SCALED_CURRENT_A + k), 32'(raw[k] * cf[k]));
            rc(12'(OFF_CUR_COEFF + 2 * k), 32'(cf[k]));
            rc(12'(OFF_CURRENT_RMS_A + 4 * k), 32'(raw[k]));
         end
      end
      $display("test scaling done");
      w(OFF_OV_THRESHOLD, 32'h1000);
      w(OFF_OC_THRESHOLD, 32'h0800);
      w(OFF_UV_THRESHOLD, 32'h0100);
      w(OFF_IRQ_MASK, 32'h3);
      // phase a sits exactly on the limit and must not trip
      pulse({24'h020000, 24'h100100, 24'h100000}, 72'h0);
      flags();
      pulse({3{24'h050000}}, 72'h0);
      flags();
      w(OFF_IRQ_FLAG, 32'h2);
      pulse({3{24'h050000}}, 72'h0);
      flags();
      w(OFF_PHASE_FLAGS_B, 32'h7);
      w(OFF_IRQ_MASK, 32'h2);
      pulse({24'h010000, 24'h050000, 24'h050000}, {48'h0, 24'h080100});
      flags();
      w(OFF_IRQ_MASK, 32'h4);
      pulse({3{24'h050000}}, 72'h0);
      for (int r = 0; r < 3; r++) begin
         pulse(72'({$urandom(), $urandom(), $urandom()}),
            72'({$urandom(), $urandom(), $urandom()}));
         flags();
      end
      $display("test flags done");
      finish_test();
   end
   initial begin
      #(40000 * 100);
      miscompares++;
      finish_test();
   end
endmodule : rlf_limit_scale_tb_top
